// *** shared/energy_cfg_pkg.sv ***
// Overview of operation
// R01 - indicator bit shows current input in use
// R02 - fault event on entry or exit, selectable
// R03 - reactive sign event direction is selectable
// R04 - active sign event direction is selectable
// R05 - reactive magnitude accumulation when bit set
// R06 - reactive negated while active power negative, when bit set
// R07 - active accumulates positive samples only when bit set
// R08 - active magnitude accumulation when bit set
// R09 - voltage gain codes 0..4 give 1..16
// R10 - current gain codes 0..4 give 1..16
// R11 - sign detect on filtered power or pulse
// R12 - software avoids unity current gain dual-input
// R13 - current input select: auto, first, second
// R14 - voltage short bit grounds voltage input
// R15 - current short bit grounds both inputs
// R16 - software keeps calibration top bits zero
// R17 - active sign change sets status flag
// R18 - fault mode change sets status flag
// R19 - reserved bits read zero, writes ignored
// R20 - indicator bit not software writable
`default_nettype none
package energy_cfg_pkg;
	// printed offsets are register indices; bus address is four times the index
	localparam logic [11:0] ACC_MODE_IDX     = 12'h00F;
	localparam logic [11:0] GAIN_CFG_IDX     = 12'h01B;
	localparam logic [11:0] CAL_CFG_IDX      = 12'h03D;
	localparam logic [11:0] EVT_STATUS_IDX   = 12'h03E;
	localparam logic [11:0] ACC_MODE_ADDR    = ACC_MODE_IDX << 2;
	localparam logic [11:0] GAIN_CFG_ADDR    = GAIN_CFG_IDX << 2;
	localparam logic [11:0] CAL_CFG_ADDR     = CAL_CFG_IDX << 2;
	localparam logic [11:0] EVT_STATUS_ADDR  = EVT_STATUS_IDX << 2;

	// accumulation mode fields
	localparam int ACC_IND_BIT        = 7;
	localparam int ACC_FAULT_SEL_BIT  = 6;
	localparam int ACC_RSIGN_SEL_BIT  = 5;
	localparam int ACC_ASIGN_SEL_BIT  = 4;
	localparam int ACC_RMAG_BIT       = 3;
	localparam int ACC_RSA_BIT        = 2;
	localparam int ACC_APOS_BIT       = 1;
	localparam int ACC_AMAG_BIT       = 0;
	localparam logic [7:0] ACC_MODE_WMASK = 8'h7F;

	// gain fields
	localparam int GAIN_V_LSB         = 5;
	localparam int GAIN_DETECT_BIT    = 3;
	localparam int GAIN_I_LSB         = 0;
	localparam logic [7:0] GAIN_CFG_WMASK = 8'hEF;
	localparam logic [2:0] GAIN_CODE_MAX  = 3'h4;

	// calibration fields
	localparam int CAL_SEL_LSB        = 4;
	localparam int CAL_VGND_BIT       = 3;
	localparam int CAL_IGND_BIT       = 2;
	localparam logic [7:0] CAL_CFG_WMASK  = 8'h3C;
	localparam logic [1:0] SEL_FIRST      = 2'h1;
	localparam logic [1:0] SEL_SECOND     = 2'h2;

	// event status bits, write one to clear
	localparam int EVT_ASIGN_BIT      = 0;
	localparam int EVT_RSIGN_BIT      = 1;
	localparam int EVT_FAULT_BIT      = 2;
	localparam logic [7:0] EVT_STATUS_MASK = 8'h07;

	localparam logic [7:0] ACC_MODE_RESET   = 8'h00;
	localparam logic [7:0] GAIN_CFG_RESET   = 8'h00;
	localparam logic [7:0] CAL_CFG_RESET    = 8'h00;
	localparam logic [7:0] EVT_STATUS_RESET = 8'h00;
endpackage
`default_nettype wire

// *** hw/energy_accum_mode_channel_cfg.sv ***
`default_nettype none
module energy_accum_mode_channel_cfg #(
	parameter int POWER_W  = 24,
	parameter int ENERGY_W = 32
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	input  wire logic signed [POWER_W-1:0]  active_power,
	input  wire logic signed [POWER_W-1:0]  reactive_power,
	input  wire logic                       power_valid,
	input  wire logic                       frequency_pulse_output,
	input  wire logic                       fault_mode,
	input  wire logic                       tamper_prefers_second,
	output logic signed [POWER_W-1:0]       active_accum_sample,
	output logic signed [POWER_W-1:0]       reactive_accum_sample,
	output logic                            accum_sample_valid,
	output logic signed [ENERGY_W-1:0]      active_energy_reg,
	output logic signed [ENERGY_W-1:0]      reactive_energy_reg,
	output logic                            active_sign_event,
	output logic                            reactive_sign_event,
	output logic                            fault_event,
	output logic [2:0]                      voltage_gain_shift,
	output logic [2:0]                      current_gain_shift,
	output logic                            current_input_second,
	output logic                            voltage_input_ground,
	output logic                            current_inputs_ground
);
	logic [7:0] accumulation_mode_cfg;
	logic [7:0] channel_gain_cfg;
	logic [7:0] channel_calibration_cfg;
	logic [7:0] event_status;
	logic [6:0] mode_bits;

	logic       active_current_input_ind;
	logic       prev_active_neg;
	logic       prev_reactive_neg;
	logic       prev_fault_mode;

	logic       setup_phase;
	logic       access_phase;
	logic       wr_fire;
	logic       hit_acc;
	logic       hit_gain;
	logic       hit_cal;
	logic       hit_evt;
	logic       addr_mapped;
	logic [7:0] rd_byte;

	logic       fault_event_select;
	logic       reactive_sign_event_select;
	logic       active_sign_event_select;
	logic       reactive_magnitude_accum;
	logic       reactive_sign_aware_accum;
	logic       active_positive_only_accum;
	logic       active_magnitude_accum;
	logic [2:0] voltage_gain_code;
	logic [2:0] current_gain_code;
	logic       sign_detect_point;
	logic [1:0] current_input_select;

	logic       active_neg;
	logic       reactive_neg;
	logic       sign_strobe;
	logic       next_active_event;
	logic       next_reactive_event;
	logic       next_fault_event;
	logic       next_second;
	logic signed [POWER_W-1:0] next_active_sample;
	logic signed [POWER_W-1:0] next_reactive_sample;

	assign fault_event_select         = accumulation_mode_cfg[energy_cfg_pkg::ACC_FAULT_SEL_BIT];
	assign reactive_sign_event_select = accumulation_mode_cfg[energy_cfg_pkg::ACC_RSIGN_SEL_BIT];
	assign active_sign_event_select   = accumulation_mode_cfg[energy_cfg_pkg::ACC_ASIGN_SEL_BIT];
	assign reactive_magnitude_accum   = accumulation_mode_cfg[energy_cfg_pkg::ACC_RMAG_BIT];
	assign reactive_sign_aware_accum  = accumulation_mode_cfg[energy_cfg_pkg::ACC_RSA_BIT];
	assign active_positive_only_accum = accumulation_mode_cfg[energy_cfg_pkg::ACC_APOS_BIT];
	assign active_magnitude_accum     = accumulation_mode_cfg[energy_cfg_pkg::ACC_AMAG_BIT];
	assign voltage_gain_code = channel_gain_cfg[energy_cfg_pkg::GAIN_V_LSB +: 3];
	assign current_gain_code = channel_gain_cfg[energy_cfg_pkg::GAIN_I_LSB +: 3];
	assign sign_detect_point = channel_gain_cfg[energy_cfg_pkg::GAIN_DETECT_BIT];
	assign current_input_select = channel_calibration_cfg[energy_cfg_pkg::CAL_SEL_LSB +: 2];

	// ---------------- apb slave ----------------
	// zero wait states; frozen clock enable stalls the access phase
	assign pready       = ce;
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;

	always_comb begin
		hit_acc     = (paddr == energy_cfg_pkg::ACC_MODE_ADDR);
		hit_gain    = (paddr == energy_cfg_pkg::GAIN_CFG_ADDR);
		hit_cal     = (paddr == energy_cfg_pkg::CAL_CFG_ADDR);
		hit_evt     = (paddr == energy_cfg_pkg::EVT_STATUS_ADDR);
		addr_mapped = hit_acc || hit_gain || hit_cal || hit_evt;
	end

	assign wr_fire = ce && access_phase && pwrite && addr_mapped && pstrb[0];

	always_comb begin
		rd_byte = 8'h00;
		if (hit_acc) begin
			rd_byte = accumulation_mode_cfg;
		end else if (hit_gain) begin
			rd_byte = channel_gain_cfg;
		end else if (hit_cal) begin
			rd_byte = channel_calibration_cfg;
		end else if (hit_evt) begin
			rd_byte = event_status;
		end
	end

	// read data is captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && setup_phase) begin
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte}; // [R19]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'h0;
		end else if (ce) begin
			if (setup_phase) begin
				pslverr <= !addr_mapped; // [R19]
			end else if (!psel) begin
				pslverr <= 1'h0;
			end
		end
	end

	// ---------------- configuration registers ----------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_bits <= energy_cfg_pkg::ACC_MODE_RESET[6:0];
		end else if (ce && wr_fire && hit_acc) begin
			// indicator bit has no flop here, so a write can never reach it
			mode_bits <= pwdata[6:0] & energy_cfg_pkg::ACC_MODE_WMASK[6:0]; // [R20]
		end
	end

	// indicator is owned by the selection logic and sits above the writable bits
	always_comb begin
		accumulation_mode_cfg = {1'h0, mode_bits};
		accumulation_mode_cfg[energy_cfg_pkg::ACC_IND_BIT] = active_current_input_ind; // [R01]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_gain_cfg <= energy_cfg_pkg::GAIN_CFG_RESET;
		end else if (ce && wr_fire && hit_gain) begin
			channel_gain_cfg <= pwdata[7:0] & energy_cfg_pkg::GAIN_CFG_WMASK; // [R19]
		end
	end

	// top bits are masked, so a careless write cannot upset the selection logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_calibration_cfg <= energy_cfg_pkg::CAL_CFG_RESET;
		end else if (ce && wr_fire && hit_cal) begin
			channel_calibration_cfg <= pwdata[7:0] & energy_cfg_pkg::CAL_CFG_WMASK; // [R16] [R19]
		end
	end

	// ---------------- channel controls ----------------
	always_comb begin
		unique case (current_input_select)
			energy_cfg_pkg::SEL_FIRST:  next_second = 1'h0; // [R13]
			energy_cfg_pkg::SEL_SECOND: next_second = 1'h1; // [R13]
			default:                    next_second = tamper_prefers_second; // [R13]
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_current_input_ind <= 1'h0;
		end else if (ce) begin
			active_current_input_ind <= next_second; // [R01]
		end
	end

	assign current_input_second = active_current_input_ind;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_input_ground <= 1'h0;
		end else if (ce) begin
			voltage_input_ground <= channel_calibration_cfg[energy_cfg_pkg::CAL_VGND_BIT]; // [R14]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_inputs_ground <= 1'h0;
		end else if (ce) begin
			current_inputs_ground <= channel_calibration_cfg[energy_cfg_pkg::CAL_IGND_BIT]; // [R15]
		end
	end

	// reserved gain codes clamp to the largest gain rather than wrapping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_gain_shift <= 3'h0;
		end else if (ce) begin
			voltage_gain_shift <= (voltage_gain_code > energy_cfg_pkg::GAIN_CODE_MAX) ?
				energy_cfg_pkg::GAIN_CODE_MAX : voltage_gain_code; // [R09]
		end
	end

	// unity gain is allowed here; dual-input overrange is left to software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_gain_shift <= 3'h0;
		end else if (ce) begin
			current_gain_shift <= (current_gain_code > energy_cfg_pkg::GAIN_CODE_MAX) ?
				energy_cfg_pkg::GAIN_CODE_MAX : current_gain_code; // [R10] [R12]
		end
	end

	// ---------------- accumulation conditioning ----------------
	assign active_neg   = active_power[POWER_W-1];
	assign reactive_neg = reactive_power[POWER_W-1];

	// magnitude of the most negative code wraps; inputs stay inside full scale
	always_comb begin
		next_active_sample = active_power;
		if (active_magnitude_accum) begin
			next_active_sample = active_neg ? -active_power : active_power; // [R08]
		end else if (active_positive_only_accum) begin
			next_active_sample = active_neg ? '0 : active_power; // [R07]
		end
	end

	always_comb begin
		next_reactive_sample = reactive_power;
		if (reactive_magnitude_accum) begin
			next_reactive_sample = reactive_neg ? -reactive_power : reactive_power; // [R05]
		end else if (reactive_sign_aware_accum) begin
			next_reactive_sample = active_neg ? -reactive_power : reactive_power; // [R06]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_accum_sample   <= '0;
			reactive_accum_sample <= '0;
			accum_sample_valid    <= 1'h0;
		end else if (ce) begin
			accum_sample_valid <= power_valid;
			if (power_valid) begin
				active_accum_sample   <= next_active_sample;
				reactive_accum_sample <= next_reactive_sample;
			end
		end
	end

	// energy registers wrap on overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_energy_reg   <= '0;
			reactive_energy_reg <= '0;
		end else if (ce && power_valid) begin
			active_energy_reg   <= active_energy_reg +
				ENERGY_W'(next_active_sample); // [R07] [R08]
			reactive_energy_reg <= reactive_energy_reg +
				ENERGY_W'(next_reactive_sample); // [R05] [R06]
		end
	end

	// ---------------- sign and fault events ----------------
	assign sign_strobe = sign_detect_point ? frequency_pulse_output : power_valid; // [R11]

	always_comb begin
		next_active_event   = 1'h0;
		next_reactive_event = 1'h0;
		if (sign_strobe) begin
			next_active_event = active_sign_event_select ?
				(prev_active_neg && !active_neg) : (!prev_active_neg && active_neg); // [R04]
			next_reactive_event = reactive_sign_event_select ?
				(prev_reactive_neg && !reactive_neg) : (!prev_reactive_neg && reactive_neg); // [R03]
		end
		next_fault_event = fault_event_select ?
			(prev_fault_mode && !fault_mode) : (!prev_fault_mode && fault_mode); // [R02]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_active_neg   <= 1'h0;
			prev_reactive_neg <= 1'h0;
		end else if (ce && sign_strobe) begin
			prev_active_neg   <= active_neg;
			prev_reactive_neg <= reactive_neg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_fault_mode <= 1'h0;
		end else if (ce) begin
			prev_fault_mode <= fault_mode;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_sign_event   <= 1'h0;
			reactive_sign_event <= 1'h0;
		end else if (ce) begin
			active_sign_event   <= next_active_event; // [R04]
			reactive_sign_event <= next_reactive_event; // [R03]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_event <= 1'h0;
		end else if (ce) begin
			fault_event <= next_fault_event; // [R02]
		end
	end

	// sticky flags; a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_status <= energy_cfg_pkg::EVT_STATUS_RESET;
		end else if (ce) begin
			if (wr_fire && hit_evt) begin
				event_status <= event_status & ~(pwdata[7:0] & energy_cfg_pkg::EVT_STATUS_MASK);
			end
			if (next_active_event) begin
				event_status[energy_cfg_pkg::EVT_ASIGN_BIT] <= 1'h1; // [R17]
			end
			if (next_reactive_event) begin
				event_status[energy_cfg_pkg::EVT_RSIGN_BIT] <= 1'h1; // [R03]
			end
			if (next_fault_event) begin
				event_status[energy_cfg_pkg::EVT_FAULT_BIT] <= 1'h1; // [R18]
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/energy_cfg_monitor.sv ***
`default_nettype none
module energy_cfg_monitor #(
	parameter int POWER_W	= 24,
	parameter int ENERGY_W	= 32
) (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic			ce,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [11:0]			paddr,
	input wire logic [31:0]			prdata,
	input wire logic			pslverr,
	input wire logic			power_valid,
	input wire logic			frequency_pulse_output,
	input wire logic			fault_mode,
	input wire logic			accum_sample_valid,
	input wire logic signed [POWER_W-1:0]	active_accum_sample,
	input wire logic signed [ENERGY_W-1:0]	active_energy_reg,
	input wire logic			active_sign_event,
	input wire logic			fault_event,
	input wire logic [2:0]			voltage_gain_shift,
	input wire logic [2:0]			current_gain_shift,
	input wire logic			current_input_second
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic	mapped;
	assign mapped = paddr inside {energy_cfg_pkg::ACC_MODE_ADDR, energy_cfg_pkg::GAIN_CFG_ADDR,
		energy_cfg_pkg::CAL_CFG_ADDR, energy_cfg_pkg::EVT_STATUS_ADDR};
	unmapped_err_a: assert property (psel && !penable && ce && !mapped |=> pslverr)
		else $error("unmapped access without error");
	read_upper_a: assert property (prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	indicator_read_a: assert property (psel && !penable && !pwrite && ce
		&& paddr == energy_cfg_pkg::ACC_MODE_ADDR |=> prdata[7] == $past(current_input_second))
		else $error("indicator read differs from selected input");
	sample_valid_a: assert property (ce |=> accum_sample_valid == $past(power_valid))
		else $error("sample valid not one cycle after power valid");
	energy_add_a: assert property (ce && power_valid |=>
		active_energy_reg == $past(active_energy_reg) + ENERGY_W'(active_accum_sample))
		else $error("active energy did not add the sample");
	sign_cause_a: assert property (active_sign_event |->
		$past(power_valid || frequency_pulse_output))
		else $error("sign event without a strobe");
	fault_cause_a: assert property (fault_event |->
		$past(fault_mode) != $past(fault_mode, 2))
		else $error("fault event without a mode change");
	gain_clamp_a: assert property (
		voltage_gain_shift <= 3'h4 && current_gain_shift <= 3'h4)
		else $error("gain shift out of range");
endmodule
bind energy_accum_mode_channel_cfg energy_cfg_monitor #(.POWER_W(POWER_W), .ENERGY_W(ENERGY_W))
	mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr, .power_valid,
	.frequency_pulse_output, .fault_mode, .accum_sample_valid, .active_accum_sample,
	.active_energy_reg, .active_sign_event, .fault_event, .voltage_gain_shift,
	.current_gain_shift, .current_input_second);
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin err_total++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, (g), (x)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 24;
	localparam logic [11:0] AM = energy_cfg_pkg::ACC_MODE_ADDR;
	localparam logic [11:0] GN = energy_cfg_pkg::GAIN_CFG_ADDR;
	localparam logic [11:0] CL = energy_cfg_pkg::CAL_CFG_ADDR;
	localparam logic [11:0] ST = energy_cfg_pkg::EVT_STATUS_ADDR;
	logic			pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic			power_valid = 1'h0, frequency_pulse_output = 1'h0, fault_mode = 1'h0;
	logic			tamper_prefers_second = 1'h0;
	logic [11:0]		paddr = 12'h000;
	logic [31:0]		pwdata = 32'h00000000;
	logic signed [PW-1:0]	active_power = 24'h000000, reactive_power = 24'h000000;
	logic			pready, pslverr, accum_sample_valid, active_sign_event;
	logic			reactive_sign_event, fault_event, current_input_second;
	logic			voltage_input_ground, current_inputs_ground;
	logic [31:0]		prdata, q;
	logic [2:0]		voltage_gain_shift, current_gain_shift;
	logic signed [PW-1:0]	active_accum_sample, reactive_accum_sample;
	logic signed [31:0]	active_energy_reg, reactive_energy_reg;
	logic [7:0]		mode = 8'h00;
	logic [7:0]		mtab [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C,
				8'h10, 8'h20, 8'h30, 8'h40, 8'h7F};
	// previous signs start positive, so a first negative sample fires
	logic			onpulse = 1'h0, pa = 1'h0, pr = 1'h0, pf = 1'h0, e, x;
	int			err_total = 0, compares = 0, cyc = 0, ea = 0, er = 0;

	energy_accum_mode_channel_cfg #(.POWER_W(PW), .ENERGY_W(32)) energy_accum_mode_channel_cfg_inst (
		.pclk, .presetn, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
		.pready, .prdata, .pslverr, .active_power, .reactive_power, .power_valid,
		.frequency_pulse_output, .fault_mode, .tamper_prefers_second, .active_accum_sample,
		.reactive_accum_sample, .accum_sample_valid, .active_energy_reg, .reactive_energy_reg,
		.active_sign_event, .reactive_sign_event, .fault_event, .voltage_gain_shift,
		.current_gain_shift, .current_input_second, .voltage_input_ground, .current_inputs_ground
	);

	always #5 pclk = ~pclk;

	task automatic wrap_up();
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// bounded by the bench timeout rather than a fixed answer time
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [7:0] d);
		xfer(1'h0, a, 8'h00);
		`CHK(q, {24'h000000, d})
	endtask

	task automatic smp(input logic v, input logic f, input logic m, input int a, input int r);
		int xa;
		int xr;
		logic xs;
		logic ys;
		logic xf;
		@(posedge pclk);
		power_valid <= v;
		frequency_pulse_output <= f;
		fault_mode <= m;
		active_power <= PW'(a);
		reactive_power <= PW'(r);
		@(posedge pclk);
		power_valid <= 1'h0;
		frequency_pulse_output <= 1'h0;
		#1;
		xa = mode[0] ? (a < 0 ? -a : a) : (mode[1] && a < 0) ? 0 : a;
		xr = mode[3] ? (r < 0 ? -r : r) : (mode[2] && a < 0) ? -r : r;
		xs = 1'h0;
		ys = 1'h0;
		if (onpulse ? f : v) begin
			xs = mode[4] ? (pa && a >= 0) : (!pa && a < 0);
			ys = mode[5] ? (pr && r >= 0) : (!pr && r < 0);
			pa = a < 0;
			pr = r < 0;
		end
		xf = mode[6] ? (pf && !m) : (!pf && m);
		pf = m;
		`CHK(active_sign_event, xs)
		`CHK(reactive_sign_event, ys)
		`CHK(fault_event, xf)
		if (v) begin
			ea += xa;
			er += xr;
			`CHK(active_accum_sample, PW'(xa))
			`CHK(reactive_accum_sample, PW'(xr))
			`CHK(active_energy_reg, ea)
			`CHK(reactive_energy_reg, er)
		end
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		rchk(AM, 8'h00);
		rchk(GN, 8'h00);
		rchk(CL, 8'h00);
		rchk(ST, 8'h00);
		xfer(1'h1, AM, 8'hFF);
		rchk(AM, 8'h7F);
		xfer(1'h1, GN, 8'hFF);
		rchk(GN, 8'hEF);
		`CHK(voltage_gain_shift, 3'h4)
		`CHK(current_gain_shift, 3'h4)
		xfer(1'h1, CL, 8'h3F);
		rchk(CL, 8'h3C);
		`CHK(voltage_input_ground, 1'h1)
		`CHK(current_inputs_ground, 1'h1)
		xfer(1'h1, AM, 8'h00);
		for (int i = 0; i < 5; i++) begin
			xfer(1'h1, GN, {i[2:0], 2'h0, 3'(i + 1)});
			repeat (2) @(posedge pclk);
			`CHK(voltage_gain_shift, i[2:0])
			`CHK(current_gain_shift, (i < 4) ? 3'(i + 1) : 3'h4)
		end
		for (int s = 0; s < 8; s++) begin
			xfer(1'h1, CL, {2'h0, s[2:1], 4'h0});
			tamper_prefers_second <= s[0];
			repeat (3) @(posedge pclk);
			x = s[2:1] == 2'h1 ? 1'h0 : s[2:1] == 2'h2 ? 1'h1 : s[0];
			`CHK(current_input_second, x)
			rchk(AM, {x, 7'h00});
		end
		`CHK(voltage_input_ground, 1'h0)
		for (int k = 0; k < 12; k++) begin
			mode = mtab[k];
			xfer(1'h1, AM, mode);
			smp(1'h1, 1'h0, 1'h1, -100, 50);
			smp(1'h1, 1'h0, 1'h0, 100, -50);
		end
		xfer(1'h1, GN, 8'h09);
		onpulse = 1'h1;
		mode = 8'h00;
		xfer(1'h1, AM, mode);
		smp(1'h1, 1'h0, 1'h0, -100, 50);
		smp(1'h0, 1'h1, 1'h0, -100, 50);
		smp(1'h0, 1'h1, 1'h0, 100, -50);
		rchk(ST, 8'h07);
		xfer(1'h1, ST, 8'h07);
		rchk(ST, 8'h00);
		xfer(1'h0, 12'h000, 8'h00);
		`CHK(e, 1'h1)
		`CHK(q, 32'h00000000)
		wrap_up();
	end
endmodule
`default_nettype wire
